// file: design/ddrtc_pkg.sv
// Package for the memory-side command timing block: commands, carriers, timing counts
package ddrtc_pkg;

    // ------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    // Least row-active time in ps (plain default)
    localparam int TRAS_PS = 40000;
    localparam int TRAS_CYC = (TRAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Termination turn-off delay in tenths of a clock
    localparam int AOFD_TCK_X10 = 25;
    localparam int AOFD_CYC = (AOFD_TCK_X10 + 9) / 10;
    // Command to internal auto precharge, in clocks (plain default)
    localparam int AP_DELAY_CYC = 4;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int DQ_LANES = 16;
    localparam int REF_CNT_W = 13;
    localparam int REF_PER_PERIOD = 8192;

    // ------------------------------------------------------------
    // Enumerations and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DDRTC_OP_NOP = 3'h0,
        DDRTC_OP_ACT = 3'h1,
        DDRTC_OP_RD = 3'h2,
        DDRTC_OP_WR = 3'h3,
        DDRTC_OP_PRE = 3'h4,
        DDRTC_OP_PREA = 3'h5,
        DDRTC_OP_REF = 3'h6,
        DDRTC_OP_MRS = 3'h7
    } ddrtc_op_t;

    typedef enum logic [1:0] {
        DDRTC_W_X4 = 2'h0,
        DDRTC_W_X8 = 2'h1,
        DDRTC_W_X16 = 2'h2
    } ddrtc_width_t;

    typedef struct packed {
        ddrtc_op_t op;
        logic [BANK_W-1:0] bank;
        logic auto_pre;
    } ddrtc_cmd_t;

endpackage

// file: design/ddrtc_bank_timer.sv
// One bank's row-active timer with auto precharge lockout
`timescale 1ns/10ps
module ddrtc_bank_timer
    import ddrtc_pkg::*;
#(
    parameter int RAS_CYC = TRAS_CYC,
    parameter int AP_CYC = AP_DELAY_CYC
)(
    input wire logic i_sys_clk,     // System clock
    input wire logic i_arst_n,      // Async reset, low
    input wire logic i_act,         // Activate this bank
    input wire logic i_pre,         // Explicit precharge of this bank
    input wire logic i_ap,          // Read or write with auto precharge
    output logic o_open,            // Row open
    output logic o_lockout,         // Auto precharge held by row-active time
    output logic o_int_pre          // Internal precharge pulse
);

    localparam int CW = $clog2(RAS_CYC + AP_CYC + 2);

    typedef enum logic [1:0] {
        DDRTC_BK_IDLE = 2'h0,
        DDRTC_BK_OPEN = 2'h1,
        DDRTC_BK_APEND = 2'h2
    } ddrtc_bk_state_t;

    ddrtc_bk_state_t state_q, state_d;
    logic [CW-1:0] ras_q, ras_d;
    logic [CW-1:0] ap_q, ap_d;
    logic open_d, lock_d, pre_d;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        ras_d = (ras_q != '0) ? CW'(ras_q - 1'b1) : ras_q;
        ap_d = (ap_q != '0) ? CW'(ap_q - 1'b1) : ap_q;
        pre_d = 1'b0;
        case (state_q)
            DDRTC_BK_IDLE:
            begin
                if (i_act)
                begin
                    state_d = DDRTC_BK_OPEN;
                    ras_d = CW'(RAS_CYC - 1);
                end
            end
            DDRTC_BK_OPEN:
            begin
                if (i_pre)
                begin
                    state_d = DDRTC_BK_IDLE;
                end
                else if (i_ap)
                begin
                    state_d = DDRTC_BK_APEND;
                    ap_d = CW'(AP_CYC - 1);
                end
            end
            DDRTC_BK_APEND:
            begin
                if (ap_q == '0 && ras_q == '0)
                begin
                    state_d = DDRTC_BK_IDLE;
                    pre_d = 1'b1;
                end
            end
            default:
            begin
                state_d = DDRTC_BK_IDLE;
            end
        endcase
        open_d = (state_d != DDRTC_BK_IDLE);
        lock_d = (state_d == DDRTC_BK_APEND) && (ap_d == '0) && (ras_d != '0);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q <= DDRTC_BK_IDLE;
            ras_q <= '0;
            ap_q <= '0;
            o_open <= 1'b0;
            o_lockout <= 1'b0;
            o_int_pre <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ras_q <= ras_d;
            ap_q <= ap_d;
            o_open <= open_d;
            o_lockout <= lock_d;
            o_int_pre <= pre_d;
        end
    end

endmodule

// file: design/ddrtc_device.sv
// Memory-side command timing: bank lockout, refresh acceptance, termination off, strobe lanes
`timescale 1ns/10ps

// Behaviour
// - Memory delays auto precharge until row-active met.
// - Refresh bursts allowed; memory accepts them.
// - Termination off 3 clocks (2.5 rounded up) after synchronised request low.
// - Strobes map to data lanes by width.
module ddrtc_device
    import ddrtc_pkg::*;
#(
    parameter int RAS_CYC = TRAS_CYC,
    parameter int AP_CYC = AP_DELAY_CYC,
    parameter int ODT_OFF_CYC = AOFD_CYC
)(
    input wire logic i_sys_clk,                 // System clock
    input wire logic i_arst_n,                  // Async reset, low
    input wire ddrtc_cmd_t i_cmd,               // Command pins, one per clock
    input wire logic i_odt,                     // Termination request pin
    input wire ddrtc_width_t i_width,           // Data width strap
    output logic [NUM_BANKS-1:0] o_bank_open,   // Banks with open rows
    output logic [NUM_BANKS-1:0] o_ap_lockout,  // Auto precharge held back
    output logic [NUM_BANKS-1:0] o_int_pre,     // Internal auto precharge pulses
    output logic [REF_CNT_W-1:0] o_ref_count,   // Refreshes accepted, wraps
    output logic o_ref_pulse,                   // Refresh accepted
    output logic o_odt_on,                      // Termination active
    output logic [DQ_LANES-1:0] o_lane_used,    // Lane carries data
    output logic [DQ_LANES-1:0] o_lane_upper    // Lane follows upper strobe
);

    localparam int OW = $clog2(ODT_OFF_CYC + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ddrtc_cmd_t cmd_s1_q, cmd_q;
    logic odt_s1_q, odt_q;
    ddrtc_width_t wid_s1_q, wid_q;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cmd_s1_q <= '{op: DDRTC_OP_NOP, bank: '0, auto_pre: 1'b0};
            cmd_q <= '{op: DDRTC_OP_NOP, bank: '0, auto_pre: 1'b0};
            odt_s1_q <= 1'b0;
            odt_q <= 1'b0;
            // No lanes until the strap has passed both flops
            wid_s1_q <= ddrtc_width_t'(2'h3);
            wid_q <= ddrtc_width_t'(2'h3);
        end
        else
        begin
            cmd_s1_q <= i_cmd;
            cmd_q <= cmd_s1_q;
            odt_s1_q <= i_odt;
            odt_q <= odt_s1_q;
            wid_s1_q <= i_width;
            wid_q <= wid_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Bank timers
    // ------------------------------------------------------------
    logic is_rw;
    assign is_rw = (cmd_q.op == DDRTC_OP_RD) || (cmd_q.op == DDRTC_OP_WR);

    genvar gb;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++)
        begin : g_bank
            logic hit;
            assign hit = (cmd_q.bank == BANK_W'(gb));
            ddrtc_bank_timer #(
                .RAS_CYC(RAS_CYC),
                .AP_CYC(AP_CYC)
            ) u_bank (
                .i_sys_clk(i_sys_clk),
                .i_arst_n(i_arst_n),
                .i_act(hit && cmd_q.op == DDRTC_OP_ACT),
                .i_pre((hit && cmd_q.op == DDRTC_OP_PRE) || cmd_q.op == DDRTC_OP_PREA),
                .i_ap(hit && is_rw && cmd_q.auto_pre),
                .o_open(o_bank_open[gb]),
                .o_lockout(o_ap_lockout[gb]),
                .o_int_pre(o_int_pre[gb])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Refresh acceptance, no interval limit
    // ------------------------------------------------------------
    logic [REF_CNT_W-1:0] ref_cnt_d;
    logic ref_pulse_d;

    always_comb
    begin
        ref_pulse_d = (cmd_q.op == DDRTC_OP_REF);
        ref_cnt_d = ref_pulse_d ? REF_CNT_W'(o_ref_count + 1'b1) : o_ref_count;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ref_count <= '0;
            o_ref_pulse <= 1'b0;
        end
        else
        begin
            o_ref_count <= ref_cnt_d;
            o_ref_pulse <= ref_pulse_d;
        end
    end

    // ------------------------------------------------------------
    // Termination turn-off delay
    // ------------------------------------------------------------
    logic [OW-1:0] odt_cnt_q, odt_cnt_d;
    logic odt_on_d;

    always_comb
    begin
        odt_cnt_d = odt_cnt_q;
        odt_on_d = o_odt_on;
        if (odt_q)
        begin
            odt_on_d = 1'b1;
            odt_cnt_d = OW'(ODT_OFF_CYC);
        end
        else if (odt_cnt_q > OW'(1))
        begin
            odt_cnt_d = OW'(odt_cnt_q - 1'b1);
        end
        else if (odt_cnt_q == OW'(1))
        begin
            odt_cnt_d = '0;
            odt_on_d = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            odt_cnt_q <= '0;
            o_odt_on <= 1'b0;
        end
        else
        begin
            odt_cnt_q <= odt_cnt_d;
            o_odt_on <= odt_on_d;
        end
    end

    // ------------------------------------------------------------
    // Strobe to lane grouping
    // ------------------------------------------------------------
    function automatic logic [1:0] lane_map(input ddrtc_width_t w, input int lane);
        logic used;
        logic upper;
        used = 1'b0;
        upper = 1'b0;
        case (w)
            DDRTC_W_X4: used = (lane < 4);
            DDRTC_W_X8: used = (lane < 8);
            DDRTC_W_X16:
            begin
                used = 1'b1;
                upper = (lane >= 8);
            end
            default: used = 1'b0;
        endcase
        return {used, upper};
    endfunction

    logic [DQ_LANES-1:0] used_d, upper_d;

    genvar gl;
    generate
        for (gl = 0; gl < DQ_LANES; gl++)
        begin : g_lane
            logic [1:0] map;
            assign map = lane_map(wid_q, gl);
            assign used_d[gl] = map[1];
            assign upper_d[gl] = map[0];
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_lane_used <= '0;
            o_lane_upper <= '0;
        end
        else
        begin
            o_lane_used <= used_d;
            o_lane_upper <= upper_d;
        end
    end

endmodule

// file: sim/ddrtc_chk.sv
// Port checker for the memory-side command timing block
`timescale 1ns/10ps
module ddrtc_chk
    import ddrtc_pkg::*;
#(
    parameter int RAS_CYC = TRAS_CYC,
    parameter int AP_CYC = AP_DELAY_CYC,
    parameter int ODT_OFF_CYC = AOFD_CYC
)(
    input wire logic i_sys_clk, // Clock
    input wire logic i_arst_n, // Reset
    input wire ddrtc_cmd_t i_cmd, // Command
    input wire logic i_odt, // Termination request
    input wire ddrtc_width_t i_width, // Width strap
    input wire logic [NUM_BANKS-1:0] o_bank_open, // Open
    input wire logic [NUM_BANKS-1:0] o_ap_lockout, // Held
    input wire logic [NUM_BANKS-1:0] o_int_pre, // Pulses
    input wire logic [REF_CNT_W-1:0] o_ref_count, // Count
    input wire logic o_ref_pulse, // Refresh
    input wire logic o_odt_on, // Termination
    input wire logic [DQ_LANES-1:0] o_lane_used, // Lanes
    input wire logic [DQ_LANES-1:0] o_lane_upper // Upper
);
    localparam int OFF_LAT = ODT_OFF_CYC + 2;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);
    function automatic logic [DQ_LANES-1:0] lane_mask(input ddrtc_width_t w);
        case (w)
            DDRTC_W_X4: return 16'h000f;
            DDRTC_W_X8: return 16'h00ff;
            DDRTC_W_X16: return 16'hffff;
            default: return 16'h0000;
        endcase
    endfunction
    sequence width_steady;
        $stable(i_width) [*5];
    endsequence
    sequence lock_ends;
        ($past(o_ap_lockout) & ~o_ap_lockout) != '0;
    endsequence
    chk_pre_one_cycle: assert property (o_int_pre != '0 |=> (o_int_pre & $past(o_int_pre)) == '0)
        else $error("precharge pulse too long");
    chk_pre_closes_row: assert property ((o_int_pre & o_bank_open) == '0)
        else $error("bank open during precharge");
    chk_lock_needs_open: assert property ((o_ap_lockout & ~o_bank_open) == '0)
        else $error("lockout on idle bank");
    chk_lock_then_pre: assert property (lock_ends |-> ##[0:1] o_int_pre != '0)
        else $error("lockout ended without precharge");
    chk_ref_accept: assert property (i_cmd.op == DDRTC_OP_REF |-> ##3 o_ref_pulse)
        else $error("refresh not accepted");
    chk_ref_origin: assert property (o_ref_pulse |-> $past(i_cmd.op, 3) == DDRTC_OP_REF)
        else $error("refresh pulse without command");
    chk_ref_count_step: assert property (o_ref_pulse |-> o_ref_count == $past(o_ref_count) + 13'h1)
        else $error("refresh count step wrong");
    chk_ref_count_hold: assert property (!o_ref_pulse |-> $stable(o_ref_count))
        else $error("refresh count moved");
    chk_odt_turn_on: assert property (i_odt |-> ##3 o_odt_on)
        else $error("termination late on");
    chk_odt_off_delay: assert property ($fell(o_odt_on) |-> !$past(i_odt, OFF_LAT))
        else $error("termination off early");
    chk_lane_group: assert property (width_steady |-> o_lane_used == lane_mask(i_width)
        && o_lane_upper == (i_width == DDRTC_W_X16 ? 16'hff00 : 16'h0000))
        else $error("lane grouping wrong");
endmodule
bind ddrtc_device ddrtc_chk #(.RAS_CYC(RAS_CYC), .AP_CYC(AP_CYC), .ODT_OFF_CYC(ODT_OFF_CYC)) u_chk (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_cmd(i_cmd), .i_odt(i_odt), .i_width(i_width),
    .o_bank_open(o_bank_open), .o_ap_lockout(o_ap_lockout), .o_int_pre(o_int_pre),
    .o_ref_count(o_ref_count), .o_ref_pulse(o_ref_pulse), .o_odt_on(o_odt_on),
    .o_lane_used(o_lane_used), .o_lane_upper(o_lane_upper));

// file: sim/ddrtc_ctrl_model.sv
// Controller model placing commands on the command pins
`timescale 1ns/10ps
module ddrtc_ctrl_model
    import ddrtc_pkg::*;
(
    input wire logic i_valid, // Command requested
    input wire ddrtc_cmd_t i_req, // Requested command
    output ddrtc_cmd_t o_cmd // Command pins
);
    always_comb
    begin
        o_cmd = '{DDRTC_OP_NOP, 3'h0, 1'b0};
        if (i_valid)
        begin
            o_cmd = i_req;
        end
    end
endmodule

// file: sim/ddrtc_tb.sv
// Testbench for the memory-side command timing block
`timescale 1ns/10ps
module testbench
    import ddrtc_pkg::*;
;
    localparam int RAS = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    ddrtc_cmd_t req = '0;
    ddrtc_cmd_t cmd;
    logic odt = 1'b0;
    ddrtc_width_t width = DDRTC_W_X16;
    logic [7:0] bank_open;
    logic [7:0] lockout;
    logic [7:0] int_pre;
    logic [12:0] ref_count;
    logic ref_pulse;
    logic odt_on;
    logic [15:0] lane_used;
    logic [15:0] lane_upper;
    int mismatches = 0;
    int checked = 0;
    int exp_refs = 0;
    always #5 clk = ~clk;
    ddrtc_ctrl_model u_ctrl (.i_valid(valid), .i_req(req), .o_cmd(cmd));
    ddrtc_device #(.RAS_CYC(RAS), .AP_CYC(4), .ODT_OFF_CYC(3)) uut (
        .i_sys_clk(clk), .i_arst_n(rst_n), .i_cmd(cmd), .i_odt(odt), .i_width(width),
        .o_bank_open(bank_open), .o_ap_lockout(lockout), .o_int_pre(int_pre), .o_ref_count(ref_count),
        .o_ref_pulse(ref_pulse), .o_odt_on(odt_on), .o_lane_used(lane_used), .o_lane_upper(lane_upper));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic send(input ddrtc_op_t op, input logic [2:0] bank, input logic ap);
        @(posedge clk);
        req <= '{op, bank, ap};
        valid <= 1'b1;
    endtask
    task automatic idle();
        @(posedge clk);
        valid <= 1'b0;
    endtask
    task automatic complete_run();
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_banks();
        for (int b = 0; b < 4; b++)
            send(DDRTC_OP_ACT, 3'(b), 1'b0);
        send(DDRTC_OP_PRE, 3'h5, 1'b0);
        send(DDRTC_OP_MRS, 3'h0, 1'b0);
        idle();
        tick(4);
        check("open four", 16'(bank_open), 16'h000f);
        send(DDRTC_OP_PREA, 3'h0, 1'b0);
        idle();
        tick(4);
        check("all closed", 16'(bank_open), 16'h0000);
    endtask
    task automatic t_lockout();
        int n;
        logic seen;
        for (int b = 0; b < 8; b++)
        begin
            n = 0;
            seen = 1'b0;
            send(DDRTC_OP_ACT, 3'(b), 1'b0);
            send(b[0] ? DDRTC_OP_WR : DDRTC_OP_RD, 3'(b), 1'b1);
            idle();
            while (int_pre[b] !== 1'b1 && n < 40)
            begin
                tick(1);
                n++;
                seen |= lockout[b];
            end
            check("lock seen", 16'(seen), 16'h0001);
            check("not early", 16'(n >= RAS), 16'h0001);
            check("not late", 16'(n <= RAS + 3), 16'h0001);
            check("pre bank", 16'(int_pre), 16'h0001 << b);
            check("closed", 16'(bank_open), 16'h0000);
        end
    endtask
    task automatic t_refresh();
        send(DDRTC_OP_ACT, 3'h6, 1'b0);
        repeat (20) send(DDRTC_OP_REF, 3'h0, 1'b0);
        send(DDRTC_OP_MRS, 3'h0, 1'b0);
        idle();
        tick(0);
        check("ref pulse", 16'(ref_pulse), 16'h0001);
        tick(4);
        exp_refs += 20;
        check("ref count", 16'(ref_count), 16'(exp_refs));
        check("ref pulse end", 16'(ref_pulse), 16'h0000);
        check("open kept", 16'(bank_open), 16'h0040);
        send(DDRTC_OP_PREA, 3'h0, 1'b0);
        idle();
    endtask
    task automatic t_odt();
        @(posedge clk);
        odt <= 1'b1;
        tick(2);
        check("odt not yet", 16'(odt_on), 16'h0000);
        tick(1);
        check("odt on", 16'(odt_on), 16'h0001);
        @(posedge clk);
        odt <= 1'b0;
        tick(4);
        check("odt held", 16'(odt_on), 16'h0001);
        tick(1);
        check("odt off", 16'(odt_on), 16'h0000);
    endtask
    task automatic t_midreset();
        send(DDRTC_OP_ACT, 3'h5, 1'b0);
        idle();
        tick(4);
        check("open five", 16'(bank_open), 16'h0020);
        @(posedge clk);
        rst_n <= 1'b0;
        tick(2);
        check("reset open", 16'(bank_open), 16'h0000);
        check("reset count", 16'(ref_count), 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        exp_refs = 0;
        tick(1);
        check("reset lanes", lane_used, 16'h0000);
    endtask
    task automatic t_lanes();
        logic [15:0] used [4] = '{16'h000f, 16'h00ff, 16'hffff, 16'h0000};
        for (int w = 0; w < 4; w++)
        begin
            @(posedge clk);
            width <= ddrtc_width_t'(w);
            tick(5);
            check("lanes used", lane_used, used[w]);
            check("lanes upper", lane_upper, w == 2 ? 16'hff00 : 16'h0000);
        end
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        check("reset state", 16'(bank_open), 16'h0000);
        t_banks();
        t_lockout();
        t_refresh();
        t_odt();
        t_midreset();
        t_lanes();
        complete_run();
    end
    initial
    begin
        #50000;
        mismatches++;
        complete_run();
    end
endmodule
